// ==== hw/dcsr_pkg.sv ====
// constants for the driver control/status and fault word pair
// assumes one system clock; command framing is done outside this block
//
// How it works
// - a control word write loads the value and answers with the result
// - bit 0 switches the output and is one after every power-on
// - bit 1 picks the analog setpoint, changeable only while bit 2 reads zero
// - with bit 6 set bit 2 mirrors the pin, else bit 2 is writable
// - bit 3 reads one only while no fault is present
// - bit 4 set makes the driver load stored defaults at power-up
// - bit 6 picks the enable source: pin when one, register bit when zero
// - bit 7 sets the analog span: min-to-max when zero, zero-to-max when one
// - any set fault bit keeps the output off
// - fault bits 1-3 and 5 come from self test and are cleared only by reset
// - fault bit 0 flags an overtemperature shutdown of the output stage
// - fault bits 1,2,3,5: config, default, handheld image, calibration check failures
// - fault bit 7 flags that the last default load failed
// - fault bit 8 flags that the maximum operating temperature was exceeded
// - fault bit 9 is one while cooling down; re-enable refused meanwhile
// - fault bit 10 warns that temperature nears the shutdown point
// - fault bit 11 flags a failure on the internal settings-memory bus
// - fault bit 12 flags pin high at power-on, shown only when bit 6 is one
// - fault bit 13 flags pin high when the source switched to the pin
// - fault bit 15 flags regulator at maximum duty without reaching setpoint
// - fault bit 16 flags output current outside its safe range
package dcsr_pkg;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_READ_CONTROL = 16'h0010;
  localparam logic [15:0] CMD_WRITE_CONTROL = 16'h0011;
  localparam logic [15:0] CMD_READ_FAULT = 16'h0020;
  localparam logic [15:0] CMD_CLEAR_FAULT = 16'h00FF;
  localparam logic [15:0] RESP_CONTROL = 16'h0110;
  localparam logic [15:0] RESP_FAULT = 16'h0120;
  localparam logic [15:0] RESP_UNKNOWN = 16'hFFFF;
  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int CTL_OUTPUT_ON = 0;
  localparam int CTL_USE_ANALOG = 1;
  localparam int CTL_ENABLE = 2;
  localparam int CTL_NO_FAULT = 3;
  localparam int CTL_BOOT_DEFAULTS = 4;
  localparam int CTL_ENABLE_FROM_PIN = 6;
  localparam int CTL_SPAN = 7;
  // ----------------------------------------------------------------
  // fault word fields
  // ----------------------------------------------------------------
  localparam int FLT_OVERTEMP_SHUTDOWN = 0;
  localparam int FLT_CONFIG_CORRUPT = 1;
  localparam int FLT_DEFAULT_CORRUPT = 2;
  localparam int FLT_HANDHELD_IMAGE_CORRUPT = 3;
  localparam int FLT_CAL_CORRUPT = 5;
  localparam int FLT_DEFAULT_LOAD_FAILED = 7;
  localparam int FLT_TEMP_EXCEEDED = 8;
  localparam int FLT_COOLING_DOWN = 9;
  localparam int FLT_NEAR_SHUTDOWN_TEMP = 10;
  localparam int FLT_TWI_FAIL = 11;
  localparam int FLT_PIN_HIGH_AT_BOOT = 12;
  localparam int FLT_PIN_HIGH_AT_SWITCH = 13;
  localparam int FLT_REGULATOR_SATURATED = 15;
  localparam int FLT_CURRENT_OUT_OF_RANGE = 16;
  // bits that only the self test may set and only reset clears
  localparam logic [31:0] FLT_SELFTEST_MASK = 32'h0000002E;
  // ----------------------------------------------------------------
  // reset values and boot timing
  // ----------------------------------------------------------------
  localparam logic [31:0] CTL_RESET = 32'h00000001;
  localparam logic [31:0] FLT_RESET = 32'h00000000;
  // cycles after release before the synchronised pin is trusted
  localparam logic [1:0] BOOT_SAMPLE_CYCLE = 2'h2;
endpackage : dcsr_pkg

// ==== hw/dcsr_regs.sv ====
// control/status and fault word pair of the current driver
// assumes commands arrive as one-cycle strobes on clock_i and that the
// enable pin is asynchronous; fault sources are levels or pulses on clock_i
`timescale 1ns/1ps
module dcsr_regs (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // command port
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_code_i,
  input wire logic [31:0] cmd_data_i,
  // answer port
  output logic resp_valid_o,
  output logic [15:0] resp_code_o,
  output logic [31:0] resp_data_o,
  // pin and stored boot setting
  input wire logic enable_pin_i,
  input wire logic boot_defaults_i,
  // fault sources
  input wire logic selftest_valid_i,
  input wire logic [3:0] selftest_fail_i,
  input wire logic overtemp_shutdown_i,
  input wire logic default_load_done_i,
  input wire logic default_load_ok_i,
  input wire logic temp_exceeded_i,
  input wire logic cooling_down_i,
  input wire logic near_shutdown_temp_i,
  input wire logic twi_fail_i,
  input wire logic regulator_saturated_i,
  input wire logic current_out_of_range_i,
  // driver controls
  output logic output_on_o,
  output logic use_analog_setpoint_o,
  output logic analog_setpoint_span_o,
  output logic default_load_req_o
);
  import dcsr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic pin_meta;
  logic pin_sync;
  logic [1:0] boot_cnt;
  logic [31:0] ctl;
  logic [31:0] flt;
  logic [31:0] next_ctl;
  logic [31:0] next_flt;
  logic [31:0] flt_vis;
  logic [31:0] ctl_vis;
  logic [31:0] next_flt_vis;
  logic [31:0] next_ctl_vis;
  logic en_eff;
  logic do_write;
  logic do_clear;
  logic boot_sample;

  // pin synchroniser; only the second stage is read
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= enable_pin_i;
      pin_sync <= pin_meta;
    end
  end

  // boot counter: the pin and the boot strap are caught once the sync is full
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      boot_cnt <= 2'h0;
    end else if (boot_cnt != 2'h3) begin
      boot_cnt <= boot_cnt + 2'h1;
    end
  end
  assign boot_sample = (boot_cnt == BOOT_SAMPLE_CYCLE);

  assign do_write = cmd_valid_i && (cmd_code_i == CMD_WRITE_CONTROL);
  assign do_clear = cmd_valid_i && (cmd_code_i == CMD_CLEAR_FAULT);

  // ----------------------------------------------------------------
  // control word
  // ----------------------------------------------------------------
  // stored bit 2 is the register enable; the read view swaps in the pin
  assign en_eff = ctl[CTL_ENABLE_FROM_PIN] ? pin_sync : ctl[CTL_ENABLE];

  always_comb begin
    next_ctl = ctl;
    if (boot_sample) begin
      next_ctl[CTL_BOOT_DEFAULTS] = boot_defaults_i;
    end
    if (do_write) begin
      // bits 0, 4, 6 and 7 take the written value; reserved and read-only bits drop
      next_ctl[CTL_OUTPUT_ON] = cmd_data_i[CTL_OUTPUT_ON];
      next_ctl[CTL_BOOT_DEFAULTS] = cmd_data_i[CTL_BOOT_DEFAULTS];
      next_ctl[CTL_ENABLE_FROM_PIN] = cmd_data_i[CTL_ENABLE_FROM_PIN];
      next_ctl[CTL_SPAN] = cmd_data_i[CTL_SPAN];
      if (!en_eff) begin
        next_ctl[CTL_USE_ANALOG] = cmd_data_i[CTL_USE_ANALOG];
      end
      // register enable is writable only while the pin is not the source
      if (!ctl[CTL_ENABLE_FROM_PIN]) begin
        // while cooling a request to turn on is refused, turn off still works
        if (!(cooling_down_i && cmd_data_i[CTL_ENABLE] && !ctl[CTL_ENABLE])) begin
          next_ctl[CTL_ENABLE] = cmd_data_i[CTL_ENABLE];
        end
      end
    end
    next_ctl[CTL_NO_FAULT] = 1'b0;
    next_ctl[5] = 1'b0;
    next_ctl[31:8] = 24'h000000;
  end

  // the on bit comes back high on every power-on
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctl <= CTL_RESET;
    end else begin
      ctl <= next_ctl;
    end
  end

  // ----------------------------------------------------------------
  // fault word
  // ----------------------------------------------------------------
  // set beats clear everywhere; self test bits ignore the clear entirely
  always_comb begin
    next_flt = flt;
    if (do_clear) begin
      next_flt = flt & FLT_SELFTEST_MASK;
    end
    if (selftest_valid_i) begin
      next_flt[FLT_CONFIG_CORRUPT] = flt[FLT_CONFIG_CORRUPT] | selftest_fail_i[0];
      next_flt[FLT_DEFAULT_CORRUPT] = flt[FLT_DEFAULT_CORRUPT] | selftest_fail_i[1];
      next_flt[FLT_HANDHELD_IMAGE_CORRUPT] = flt[FLT_HANDHELD_IMAGE_CORRUPT] |
                                             selftest_fail_i[2];
      next_flt[FLT_CAL_CORRUPT] = flt[FLT_CAL_CORRUPT] | selftest_fail_i[3];
    end
    if (overtemp_shutdown_i) next_flt[FLT_OVERTEMP_SHUTDOWN] = 1'b1;
    if (default_load_done_i) begin
      next_flt[FLT_DEFAULT_LOAD_FAILED] = !default_load_ok_i;
    end
    if (temp_exceeded_i) next_flt[FLT_TEMP_EXCEEDED] = 1'b1;
    // cooling and warning follow their source as levels
    next_flt[FLT_COOLING_DOWN] = cooling_down_i;
    next_flt[FLT_NEAR_SHUTDOWN_TEMP] = near_shutdown_temp_i;
    if (twi_fail_i) next_flt[FLT_TWI_FAIL] = 1'b1;
    if (boot_sample && pin_sync) next_flt[FLT_PIN_HIGH_AT_BOOT] = 1'b1;
    if (do_write && cmd_data_i[CTL_ENABLE_FROM_PIN] && !ctl[CTL_ENABLE_FROM_PIN] && pin_sync) begin
      next_flt[FLT_PIN_HIGH_AT_SWITCH] = 1'b1;
    end
    if (regulator_saturated_i) next_flt[FLT_REGULATOR_SATURATED] = 1'b1;
    if (current_out_of_range_i) next_flt[FLT_CURRENT_OUT_OF_RANGE] = 1'b1;
    next_flt[4] = 1'b0;
    next_flt[6] = 1'b0;
    next_flt[14] = 1'b0;
    next_flt[31:17] = 15'h0000;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      flt <= FLT_RESET;
    end else begin
      flt <= next_flt;
    end
  end

  // ----------------------------------------------------------------
  // read views
  // ----------------------------------------------------------------
  // the boot pin flag is only meaningful with the pin as enable source
  function automatic logic [31:0] flt_view(input logic [31:0] f, input logic from_pin);
    logic [31:0] v;
    v = f;
    v[FLT_PIN_HIGH_AT_BOOT] = f[FLT_PIN_HIGH_AT_BOOT] & from_pin;
    return v;
  endfunction : flt_view

  function automatic logic [31:0] ctl_view(input logic [31:0] c, input logic [31:0] fv,
                                           input logic pin);
    logic [31:0] v;
    v = c;
    if (c[CTL_ENABLE_FROM_PIN]) v[CTL_ENABLE] = pin;
    v[CTL_NO_FAULT] = (fv == 32'h00000000);
    return v;
  endfunction : ctl_view

  assign flt_vis = flt_view(flt, ctl[CTL_ENABLE_FROM_PIN]);
  assign ctl_vis = ctl_view(ctl, flt_vis, pin_sync);
  assign next_flt_vis = flt_view(next_flt, next_ctl[CTL_ENABLE_FROM_PIN]);
  assign next_ctl_vis = ctl_view(next_ctl, next_flt_vis, pin_sync);

  // ----------------------------------------------------------------
  // answers
  // ----------------------------------------------------------------
  // answer shows the state as it stands after the command took effect
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      resp_valid_o <= 1'b0;
      resp_code_o <= 16'h0000;
      resp_data_o <= 32'h00000000;
    end else begin
      resp_valid_o <= cmd_valid_i;
      if (cmd_valid_i) begin
        case (cmd_code_i)
          CMD_READ_CONTROL, CMD_WRITE_CONTROL: begin
            resp_code_o <= RESP_CONTROL;
            resp_data_o <= next_ctl_vis;
          end
          CMD_READ_FAULT, CMD_CLEAR_FAULT: begin
            resp_code_o <= RESP_FAULT;
            resp_data_o <= next_flt_vis;
          end
          default: begin
            resp_code_o <= RESP_UNKNOWN;
            resp_data_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // driver controls
  // ----------------------------------------------------------------
  // any fault, warning included, keeps the stage off
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      output_on_o <= 1'b0;
      use_analog_setpoint_o <= 1'b0;
      analog_setpoint_span_o <= 1'b0;
    end else begin
      output_on_o <= ctl[CTL_OUTPUT_ON] && en_eff && (flt_vis == 32'h00000000);
      use_analog_setpoint_o <= next_ctl[CTL_USE_ANALOG];
      analog_setpoint_span_o <= next_ctl[CTL_SPAN];
    end
  end

  // one pulse after release when the stored boot setting asks for defaults
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      default_load_req_o <= 1'b0;
    end else begin
      default_load_req_o <= boot_sample && boot_defaults_i;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_resp_one_cycle: assert property (@(posedge clock_i) disable iff (rst_i)
    cmd_valid_i |=> resp_valid_o)
    else $error("command not answered in one cycle");

  // the pin may move under the answer, so the mirrored enable bit is checked elsewhere
  a_write_echo_state: assert property (@(posedge clock_i) disable iff (rst_i)
    do_write |=> (resp_code_o == RESP_CONTROL) && (resp_data_o[31:3] == ctl_vis[31:3]) &&
      (resp_data_o[1:0] == ctl_vis[1:0]) &&
      (ctl[CTL_ENABLE_FROM_PIN] || (resp_data_o[CTL_ENABLE] == ctl[CTL_ENABLE])))
    else $error("write answer differs from register");

  a_fault_forces_off: assert property (@(posedge clock_i) disable iff (rst_i)
    (flt_vis != 32'h00000000) |=> !output_on_o)
    else $error("output on while a fault is set");

  a_no_fault_bit: assert property (@(posedge clock_i) disable iff (rst_i)
    resp_valid_o && (resp_code_o == RESP_CONTROL) |->
      resp_data_o[CTL_NO_FAULT] == (flt_vis == 32'h00000000))
    else $error("no-fault bit disagrees with fault word");

  // every self test bit that was set must still be set, one by one
  a_selftest_sticky: assert property (@(posedge clock_i) disable iff (rst_i)
    (flt & FLT_SELFTEST_MASK) != 32'h00000000 |=>
      (flt & $past(flt) & FLT_SELFTEST_MASK) == ($past(flt) & FLT_SELFTEST_MASK))
    else $error("self test fault bit was cleared");

  a_overtemp_latched: assert property (@(posedge clock_i) disable iff (rst_i)
    overtemp_shutdown_i |=> flt[FLT_OVERTEMP_SHUTDOWN])
    else $error("overtemperature flag not latched");

  a_cooling_mirror: assert property (@(posedge clock_i) disable iff (rst_i)
    cooling_down_i |=> flt[FLT_COOLING_DOWN])
    else $error("cooling flag does not follow its source");

  a_span_follows_write: assert property (@(posedge clock_i) disable iff (rst_i)
    do_write |=> analog_setpoint_span_o == $past(cmd_data_i[CTL_SPAN]))
    else $error("span output did not take written value");

  a_cool_refuses_on: assert property (@(posedge clock_i) disable iff (rst_i)
    cooling_down_i && !ctl[CTL_ENABLE] ##0 do_write |=> !ctl[CTL_ENABLE])
    else $error("enable accepted while cooling down");

  a_pin_drives_enable: assert property (@(posedge clock_i) disable iff (rst_i)
    resp_valid_o && (resp_code_o == RESP_CONTROL) && ctl[CTL_ENABLE_FROM_PIN] |->
      resp_data_o[CTL_ENABLE] == $past(pin_sync))
    else $error("enable bit does not mirror pin");

  a_setpoint_locked: assert property (@(posedge clock_i) disable iff (rst_i)
    en_eff && do_write |=> $stable(ctl[CTL_USE_ANALOG]))
    else $error("setpoint source changed while enabled");

  a_switch_pin_flag: assert property (@(posedge clock_i) disable iff (rst_i)
    do_write && cmd_data_i[CTL_ENABLE_FROM_PIN] && !ctl[CTL_ENABLE_FROM_PIN] && pin_sync
    |=> flt[FLT_PIN_HIGH_AT_SWITCH])
    else $error("pin-high-at-switch flag not set");

  a_reserved_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    ctl_vis[31:8] == 24'h000000 && flt[31:17] == 15'h0000 ##0 !ctl_vis[5])
    else $error("reserved bit reads nonzero");
endmodule : dcsr_regs

// ==== tb/dcsr_host.sv ====
// host-side model: sends one command at a time on the strobe port
// assumes the bench calls issue() from its main sequence only
`timescale 1ns/1ps
module dcsr_host (
  // clock
  input wire logic clock_i,
  // command port toward the register pair
  output logic cmd_valid_o,
  output logic [15:0] cmd_code_o,
  output logic [31:0] cmd_data_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = 16'h0000;
    cmd_data_o = 32'h00000000;
  end
  // ----------------------------------------------------------------
  // one command, strobe held through the taking edge only
  // ----------------------------------------------------------------
  // whole words only: the caller does read-modify-write for single bits
  task automatic issue(input logic [15:0] code, input logic [31:0] data);
    @(posedge clock_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o <= code;
    cmd_data_o <= data;
    @(posedge clock_i);
    // released lines carry inverted junk so a stale word never looks valid
    cmd_valid_o <= 1'b0;
    cmd_code_o <= ~code;
    cmd_data_o <= ~data;
  endtask : issue
endmodule : dcsr_host

// ==== tb/driver_control_status_regs_test.sv ====
// self-checking bench for the control/status and fault word pair
// assumes the host model drives commands; fault sources come from here
`timescale 1ns/1ps
module driver_control_status_regs_test;
  import dcsr_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i;
  logic [15:0] cmd_code_i;
  logic [31:0] cmd_data_i;
  logic resp_valid_o;
  logic [15:0] resp_code_o;
  logic [31:0] resp_data_o;
  logic enable_pin_i = 1'b0;
  logic boot_defaults_i = 1'b0;
  logic selftest_valid_i = 1'b0;
  logic [3:0] selftest_fail_i = 4'h0;
  logic ot_i = 1'b0;
  logic done_i = 1'b0;
  logic ok_i = 1'b1;
  logic hot_i = 1'b0;
  logic cooling_down_i = 1'b0;
  logic near_shutdown_temp_i = 1'b0;
  logic twi_i = 1'b0;
  logic sat_i = 1'b0;
  logic cur_i = 1'b0;
  logic output_on_o;
  logic use_analog_setpoint_o;
  logic analog_setpoint_span_o;
  logic default_load_req_o;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 18256;
  int ctl;
  int flt;
  int pin;
  int fbit[6] = '{0, 8, 11, 15, 16, 7};
  always #2 clock_i = ~clock_i;
  dcsr_host host (.clock_i(clock_i), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
    .cmd_data_o(cmd_data_i));
  dcsr_regs dut (.clock_i(clock_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .cmd_data_i(cmd_data_i), .resp_valid_o(resp_valid_o),
    .resp_code_o(resp_code_o), .resp_data_o(resp_data_o), .enable_pin_i(enable_pin_i),
    .boot_defaults_i(boot_defaults_i), .selftest_valid_i(selftest_valid_i),
    .selftest_fail_i(selftest_fail_i), .overtemp_shutdown_i(ot_i),
    .default_load_done_i(done_i), .default_load_ok_i(ok_i), .temp_exceeded_i(hot_i),
    .cooling_down_i(cooling_down_i), .near_shutdown_temp_i(near_shutdown_temp_i),
    .twi_fail_i(twi_i), .regulator_saturated_i(sat_i), .current_out_of_range_i(cur_i),
    .output_on_o(output_on_o), .use_analog_setpoint_o(use_analog_setpoint_o),
    .analog_setpoint_span_o(analog_setpoint_span_o), .default_load_req_o(default_load_req_o));
  // ----------------------------------------------------------------
  // reference model of both words
  // ----------------------------------------------------------------
  // pin is only changed with several idle cycles after, so the synced copy equals it
  function automatic int en();
    return ctl[6] ? pin : ctl[2];
  endfunction : en
  // pin-at-boot flag shows only with pin as enable source; bits 9/10 are live levels
  function automatic int fview();
    return (flt & ~32'h1000) | (ctl[6] ? flt & 32'h1000 : 0)
      | (int'(cooling_down_i) << 9) | (int'(near_shutdown_temp_i) << 10);
  endfunction : fview
  function automatic int view();
    return (ctl & 32'hD3) | (en() << 2) | (int'(fview() == 0) << 3);
  endfunction : view
  // ----------------------------------------------------------------
  // comparisons and closing
  // ----------------------------------------------------------------
  task automatic chk_resp(input logic [15:0] c, input logic [31:0] d);
    compares++;
    if (resp_valid_o !== 1'b1 || resp_code_o !== c || resp_data_o !== d) begin
      failures++;
      $display("mismatch t=%0t answer %h %h want %h %h", $time, resp_code_o, resp_data_o, c, d);
    end
  endtask : chk_resp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t value %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // hang guard: the whole sequence needs well under a thousand commands
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // command helpers
  // ----------------------------------------------------------------
  task automatic run(input logic [15:0] code, input logic [31:0] data, input logic [15:0] rc);
    host.issue(code, data);
    #1;
    chk_resp(rc, (rc == RESP_CONTROL) ? view() : (rc == RESP_FAULT) ? fview() : 0);
    chk(use_analog_setpoint_o, ctl[1]);
    chk(analog_setpoint_span_o, ctl[7]);
    @(posedge clock_i);
    #1;
    chk(output_on_o, ctl[0] & en() & int'(fview() == 0));
  endtask : run
  // refusals follow the old stored state, so the model updates before sending
  task automatic wr(input logic [31:0] d);
    int n;
    n = d & 32'hD7;
    if (en()) n[1] = ctl[1];
    if (ctl[6]) n[2] = ctl[2];
    else if (cooling_down_i && !ctl[2]) n[2] = 0;
    if (!ctl[6] && n[6] && pin) flt[13] = 1;
    ctl = n;
    run(CMD_WRITE_CONTROL, d, RESP_CONTROL);
  endtask : wr
  task automatic clr();
    flt &= 32'h2E;
    run(CMD_CLEAR_FAULT, 0, RESP_FAULT);
  endtask : clr
  task automatic do_reset(input int p, input int b);
    int k;
    @(posedge clock_i);
    enable_pin_i <= p[0];
    boot_defaults_i <= b[0];
    rst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    ctl = 1 | (b << 4);
    flt = p << 12;
    pin = p;
    k = 0;
    repeat (6) begin
      @(posedge clock_i);
      #1;
      k += default_load_req_o;
    end
    chk(k, b);
  endtask : do_reset
  // one-cycle pulse on fault source k, then time for the flag to land
  task automatic fpulse(input int k);
    @(posedge clock_i);
    case (k)
      0: ot_i <= 1'b1;
      1: hot_i <= 1'b1;
      2: twi_i <= 1'b1;
      3: sat_i <= 1'b1;
      4: cur_i <= 1'b1;
      default: begin
        done_i <= 1'b1;
        ok_i <= 1'b0;
      end
    endcase
    @(posedge clock_i);
    {ot_i, hot_i, twi_i, sat_i, cur_i, done_i} <= 6'h00;
    ok_i <= 1'b1;
    flt |= 1 << fbit[k];
    repeat (2) @(posedge clock_i);
  endtask : fpulse
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int f;
    do_reset(0, 1);
    run(CMD_READ_CONTROL, 0, RESP_CONTROL);
    run(16'h0033, 32'hFFFFFFFF, RESP_UNKNOWN);
    // random full words with the pin low then high, reserved bits included
    for (int b = 0; b < 4; b++) begin
      @(posedge clock_i);
      enable_pin_i <= b[1];
      pin = b[1];
      repeat (4) @(posedge clock_i);
      repeat (12) wr($random(seed));
      clr();
    end
    wr(32'h1);
    @(posedge clock_i);
    enable_pin_i <= 1'b0;
    pin = 0;
    repeat (4) @(posedge clock_i);
    wr(32'h5);
    for (int k = 0; k < 6; k++) begin
      fpulse(k);
      run(CMD_READ_FAULT, 0, RESP_FAULT);
      clr();
    end
    wr(32'h1);
    @(posedge clock_i);
    cooling_down_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    wr(32'h5);
    clr();
    @(posedge clock_i);
    {cooling_down_i, near_shutdown_temp_i} <= 2'b01;
    repeat (3) @(posedge clock_i);
    wr(32'h5);
    @(posedge clock_i);
    near_shutdown_temp_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    run(CMD_READ_CONTROL, 0, RESP_CONTROL);
    // self-test failures survive the clear command
    f = ($random(seed) & 15) | 1;
    @(posedge clock_i);
    selftest_valid_i <= 1'b1;
    selftest_fail_i <= f[3:0];
    @(posedge clock_i);
    selftest_valid_i <= 1'b0;
    flt |= (f & 7) << 1 | (f >> 3) << 5;
    repeat (2) @(posedge clock_i);
    clr();
    run(CMD_READ_FAULT, 0, RESP_FAULT);
    // second reset with the pin held high through boot
    do_reset(1, 0);
    run(CMD_READ_FAULT, 0, RESP_FAULT);
    wr(32'h41);
    run(CMD_READ_FAULT, 0, RESP_FAULT);
    summarize();
  end
endmodule : driver_control_status_regs_test
